// ===== core/cca_pkg.sv
// Constants, register map and field layout of the counter array
package cca_pkg;

    // Structure
    localparam int CCA_NMOD    = 5;
    localparam int CCA_CNT_W   = 16;
    localparam int CCA_MODE_W  = 7;
    localparam int CCA_WDT_MOD = 4;

    // Register addresses on the special function register port
    localparam logic [7:0] CCA_ADR_COUNTER_RUN_AND_FLAGS  = 8'hD8;
    localparam logic [7:0] CCA_ADR_COUNTER_MODE_CONTROL  = 8'hD9;
    localparam logic [7:0] CCA_ADR_MODE0 = 8'hDA;
    localparam logic [7:0] CCA_ADR_CL    = 8'hE0;
    localparam logic [7:0] CCA_ADR_CH    = 8'hE1;
    localparam logic [7:0] CCA_ADR_VLO0  = 8'hE2;
    localparam logic [7:0] CCA_ADR_VHI0  = 8'hE8;

    // Counter mode control fields
    localparam int CCA_CM_IDLE   = 7;
    localparam int CCA_CM_MODULE4_WATCHDOG_ENABLE   = 6;
    localparam int CCA_CM_SRC_HI = 2;
    localparam int CCA_CM_SRC_LO = 1;
    localparam int CCA_CM_OVIE   = 0;

    // Counter run and flags fields
    localparam int CCA_CC_OVF = 7;
    localparam int CCA_CC_RUN = 6;

    // Module mode register fields
    localparam int CCA_MD_IRQ  = 0;
    localparam int CCA_MD_PWM  = 1;
    localparam int CCA_MD_TOG  = 2;
    localparam int CCA_MD_MAT  = 3;
    localparam int CCA_MD_FALLING_EDGE_CAPTURE_ENABLE = 4;
    localparam int CCA_MD_RISING_EDGE_CAPTURE_ENABLE = 5;
    localparam int CCA_MD_COMP = 6;

    // Writable bits and reset values
    localparam logic [7:0] CCA_COUNTER_MODE_CONTROL_MASK = 8'hC7;
    localparam logic [7:0] CCA_COUNTER_MODE_CONTROL_RST  = 8'h00;
    localparam logic [6:0] CCA_MODE_RST  = 7'h00;
    localparam logic [7:0] CCA_BYTE_ZERO = 8'h00;

    // Port 1 pin positions
    localparam int CCA_PIN_ECI  = 2;
    localparam int CCA_PIN_MOD0 = 3;

    // Oscillator prescaler
    localparam logic [2:0] CCA_DIV6_LAST = 3'h5;
    localparam logic [2:0] CCA_PRE_RST   = 3'h0;

    typedef enum logic [1:0] {
        CCA_SRC_DIV6,
        CCA_SRC_DIV2,
        CCA_SRC_T0,
        CCA_SRC_EXT
    } cca_src_t;

endpackage

// ===== core/cca_module.sv
// One capture/compare module: value register, capture, compare, toggle, PWM
`timescale 1ns/10ps
`default_nettype none
module cca_module #(
    parameter int CNT_W = cca_pkg::CCA_CNT_W
) (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    // Control from the register file
    input  wire logic [cca_pkg::CCA_MODE_W-1:0] mode,
    input  wire logic                        wr_lo,
    input  wire logic                        wr_hi,
    input  wire logic [7:0]                  wdata,
    // Shared time base
    input  wire logic [CNT_W-1:0]            cnt,
    input  wire logic                        cnt_new,
    // Pin
    input  wire logic                        pin_in,
    output logic                             pin_out,
    output logic                             pin_drive,
    // Status
    output logic [CNT_W-1:0]                 val,
    output logic                             match_p,
    output logic                             event_p
);
    import cca_pkg::*;

    logic [CNT_W-1:0] val_q;
    logic             pin_q;
    logic             pin_out_q;
    logic             cap;
    logic             lo_wrap;

    assign cap = ((pin_in & ~pin_q) & mode[CCA_MD_RISING_EDGE_CAPTURE_ENABLE])
               | ((~pin_in & pin_q) & mode[CCA_MD_FALLING_EDGE_CAPTURE_ENABLE]);
    assign match_p = mode[CCA_MD_COMP] & cnt_new & (cnt == val_q);
    assign lo_wrap = cnt_new & (cnt[7:0] == CCA_BYTE_ZERO);
    assign event_p = cap | (match_p & mode[CCA_MD_MAT]);
    assign pin_drive = mode[CCA_MD_PWM] | mode[CCA_MD_TOG];
    assign pin_out = pin_out_q;
    assign val = val_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_q <= 1'b1;
        end else begin
            pin_q <= pin_in;
        end
    end

    // Software writes win over capture and PWM reload
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            val_q <= '0;
        end else if (wr_lo) begin
            val_q[7:0] <= wdata;
        end else if (wr_hi) begin
            val_q[CNT_W-1:8] <= wdata;
        end else if (cap) begin
            val_q <= cnt;
        end else if (mode[CCA_MD_PWM] && lo_wrap) begin
            val_q[7:0] <= val_q[CNT_W-1:8];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_out_q <= 1'b1;
        end else if (mode[CCA_MD_PWM]) begin
            pin_out_q <= (cnt[7:0] >= val_q[7:0]);
        end else if (match_p && mode[CCA_MD_TOG]) begin
            pin_out_q <= ~pin_out_q;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    capture_load_a: assert property (
        (cap && !wr_lo && !wr_hi) |=> (val_q == $past(cnt)))
        else $error("capture did not load counter");

    toggle_pin_a: assert property (
        (match_p && mode[CCA_MD_TOG] && !mode[CCA_MD_PWM]) |=> (pin_out != $past(pin_out)))
        else $error("pin did not toggle on match");

    pwm_duty_a: assert property (
        mode[CCA_MD_PWM] |=> (pin_out == ($past(cnt[7:0]) >= $past(val_q[7:0]))))
        else $error("pwm output wrong");

endmodule
`default_nettype wire

// ===== core/cca_top.sv
// Counter array: shared time base, five capture/compare modules, registers
// Functional notes
// - One free-running 16-bit counter, shared time base
// - Count source chosen by two-bit select field
// - Counter runs only while run bit set
// - Overflow sets flag; only software clears it
// - Overflow interrupt only when its enable set
// - Per-module flag set by match or capture
// - All interrupts merge into one request
// - Module flag interrupts only with module enable
// - PWM mode: duty set by value register
// - Toggle pin on counter equal to value
// - Set module flag on counter equal value
// - Capture on falling, rising or both edges
// - Comparator enable bit gates the comparison
// - Value register captures or holds compare value
// - Idle gate bit stops counter in idle
// - Watchdog function on module four enabled
// - Modules use port bits three up; count pin two
// - Mode control resets to zero
// - Source codes: /6, /2, timer 0, pin
`timescale 1ns/10ps
`default_nettype none
module cca_top #(
    parameter int CNT_W = cca_pkg::CCA_CNT_W
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Special function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    output logic [7:0]      sfr_rdata,
    // Core status
    input  wire logic       idle_mode,
    input  wire logic       timer0_ovf,
    // Port 1 pins
    input  wire logic [7:0] p1_in,
    output logic [7:0]      p1_out,
    output logic [7:0]      p1_oe_n,
    // Requests
    output logic            irq,
    output logic            wdt_reset
);
    import cca_pkg::*;

    localparam int NMOD = CCA_NMOD;

    logic [CNT_W-1:0]      cnt_q;
    logic                  cnt_new_q;
    logic [2:0]            presc_q;
    logic                  eci_q;
    logic [7:0]            counter_mode_control_q;
    logic                  cf_q;
    logic                  cr_q;
    logic [NMOD-1:0]       ccf_q;
    logic [CCA_MODE_W-1:0] mode_q [NMOD];
    logic [7:0]            rdata_q;
    logic                  wdt_q;

    logic                  wr_counter_run_and_flags;
    logic                  wr_counter_mode_control;
    logic                  wr_cl;
    logic                  wr_ch;
    logic                  cnt_wr;
    logic                  src_tick;
    logic                  run_en;
    logic                  cnt_tick;
    logic                  ovf;
    logic                  ext_tick;
    cca_src_t              src_sel;
    logic [7:0]            rd_d;
    logic [7:0]            counter_run_and_flags_rd;
    logic [NMOD-1:0]       ev;
    logic [NMOD-1:0]       mt;
    logic [NMOD-1:0]       irq_en;
    logic [NMOD-1:0]       wr_mode;
    logic [NMOD-1:0]       wr_vlo;
    logic [NMOD-1:0]       wr_vhi;
    logic [CNT_W-1:0]      val [NMOD];

    // Write decode
    assign wr_counter_run_and_flags = sfr_wr && (sfr_addr == CCA_ADR_COUNTER_RUN_AND_FLAGS);
    assign wr_counter_mode_control = sfr_wr && (sfr_addr == CCA_ADR_COUNTER_MODE_CONTROL);
    assign wr_cl   = sfr_wr && (sfr_addr == CCA_ADR_CL);
    assign wr_ch   = sfr_wr && (sfr_addr == CCA_ADR_CH);
    assign cnt_wr  = wr_cl | wr_ch;

    // Count source selection
    assign src_sel  = cca_src_t'(counter_mode_control_q[CCA_CM_SRC_HI:CCA_CM_SRC_LO]);
    assign ext_tick = eci_q & ~p1_in[CCA_PIN_ECI];

    always_comb begin
        case (src_sel)
            CCA_SRC_DIV6: src_tick = (presc_q == CCA_DIV6_LAST);
            CCA_SRC_DIV2: src_tick = presc_q[0];
            CCA_SRC_T0:   src_tick = timer0_ovf;
            default:      src_tick = ext_tick;
        endcase
    end

    assign run_en   = cr_q & ~(idle_mode & counter_mode_control_q[CCA_CM_IDLE]);
    assign cnt_tick = run_en & src_tick & ~cnt_wr;
    assign ovf      = cnt_tick & (&cnt_q);

    // Oscillator prescaler, bit 0 alternates every cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            presc_q <= CCA_PRE_RST;
        end else if (presc_q == CCA_DIV6_LAST) begin
            presc_q <= CCA_PRE_RST;
        end else begin
            presc_q <= presc_q + 3'h1;
        end
    end

    // External count pin falls between two samples
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            eci_q <= 1'b1;
        end else begin
            eci_q <= p1_in[CCA_PIN_ECI];
        end
    end

    // Shared counter; software byte writes win over counting
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (wr_cl) begin
            cnt_q[7:0] <= sfr_wdata;
        end else if (wr_ch) begin
            cnt_q[CNT_W-1:8] <= sfr_wdata;
        end else if (cnt_tick) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Marks the cycle in which the counter holds a fresh value
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_new_q <= 1'b0;
        end else begin
            cnt_new_q <= cnt_tick;
        end
    end

    // Counter mode control; reserved bits never stored
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            counter_mode_control_q <= CCA_COUNTER_MODE_CONTROL_RST;
        end else if (wr_counter_mode_control) begin
            counter_mode_control_q <= sfr_wdata & CCA_COUNTER_MODE_CONTROL_MASK;
        end
    end

    // Run bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cr_q <= 1'b0;
        end else if (wr_counter_run_and_flags) begin
            cr_q <= sfr_wdata[CCA_CC_RUN];
        end
    end

    // Overflow flag: hardware set wins over a software clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cf_q <= 1'b0;
        end else if (ovf) begin
            cf_q <= 1'b1;
        end else if (wr_counter_run_and_flags) begin
            cf_q <= sfr_wdata[CCA_CC_OVF];
        end
    end

    // Module flags, same set-wins rule
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ccf_q <= '0;
        end else if (wr_counter_run_and_flags) begin
            ccf_q <= sfr_wdata[NMOD-1:0] | ev;
        end else begin
            ccf_q <= ccf_q | ev;
        end
    end

    // Module mode registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int n = 0; n < NMOD; n++) begin
                mode_q[n] <= CCA_MODE_RST;
            end
        end else begin
            for (int n = 0; n < NMOD; n++) begin
                if (wr_mode[n]) begin
                    mode_q[n] <= sfr_wdata[CCA_MODE_W-1:0];
                end
            end
        end
    end

    // Modules and their pins
    assign p1_out[CCA_PIN_MOD0-1:0]  = '1;
    assign p1_oe_n[CCA_PIN_MOD0-1:0] = '1;

    for (genvar g = 0; g < NMOD; g++) begin : g_mod
        logic pin_o;
        logic pin_drv;

        assign wr_mode[g] = sfr_wr && (sfr_addr == CCA_ADR_MODE0 + 8'(g));
        assign wr_vlo[g]  = sfr_wr && (sfr_addr == CCA_ADR_VLO0 + 8'(g));
        assign wr_vhi[g]  = sfr_wr && (sfr_addr == CCA_ADR_VHI0 + 8'(g));
        assign irq_en[g]  = mode_q[g][CCA_MD_IRQ];

        cca_module #(
            .CNT_W (CNT_W)
        ) u_mod (
            .ref_clk   (ref_clk),
            .rst       (rst),
            .mode      (mode_q[g]),
            .wr_lo     (wr_vlo[g]),
            .wr_hi     (wr_vhi[g]),
            .wdata     (sfr_wdata),
            .cnt       (cnt_q),
            .cnt_new   (cnt_new_q),
            .pin_in    (p1_in[CCA_PIN_MOD0+g]),
            .pin_out   (pin_o),
            .pin_drive (pin_drv),
            .val       (val[g]),
            .match_p   (mt[g]),
            .event_p   (ev[g])
        );

        assign p1_out[CCA_PIN_MOD0+g]  = pin_drv ? pin_o : 1'b1;
        assign p1_oe_n[CCA_PIN_MOD0+g] = ~pin_drv;

        flag_set_a: assert property (@(posedge ref_clk) disable iff (rst)
            ev[g] |=> ccf_q[g])
            else $error("module flag not set by event");
    end

    // Shared interrupt request
    assign irq = (cf_q & counter_mode_control_q[CCA_CM_OVIE])
               | (|(ccf_q & irq_en));

    // Watchdog match on module 4
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wdt_q <= 1'b0;
        end else begin
            wdt_q <= counter_mode_control_q[CCA_CM_MODULE4_WATCHDOG_ENABLE] & mt[CCA_WDT_MOD]
                   & mode_q[CCA_WDT_MOD][CCA_MD_MAT];
        end
    end
    assign wdt_reset = wdt_q;

    // Read path; unmapped addresses read zero
    assign counter_run_and_flags_rd = {cf_q, cr_q, 1'b0, ccf_q};

    always_comb begin
        rd_d = CCA_BYTE_ZERO;
        if (sfr_addr == CCA_ADR_COUNTER_RUN_AND_FLAGS) begin
            rd_d = counter_run_and_flags_rd;
        end else if (sfr_addr == CCA_ADR_COUNTER_MODE_CONTROL) begin
            rd_d = counter_mode_control_q;
        end else if (sfr_addr == CCA_ADR_CL) begin
            rd_d = cnt_q[7:0];
        end else if (sfr_addr == CCA_ADR_CH) begin
            rd_d = cnt_q[CNT_W-1:8];
        end else begin
            for (int n = 0; n < NMOD; n++) begin
                if (sfr_addr == CCA_ADR_MODE0 + 8'(n)) begin
                    rd_d = {1'b0, mode_q[n]};
                end else if (sfr_addr == CCA_ADR_VLO0 + 8'(n)) begin
                    rd_d = val[n][7:0];
                end else if (sfr_addr == CCA_ADR_VHI0 + 8'(n)) begin
                    rd_d = val[n][CNT_W-1:8];
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= CCA_BYTE_ZERO;
        end else if (sfr_rd) begin
            rdata_q <= rd_d;
        end
    end
    assign sfr_rdata = rdata_q;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_div6_tick;
        cnt_tick && (src_sel == CCA_SRC_DIV6);
    endsequence

    // A source change by software may legally move the next tick
    sequence s_quiet5;
        !(cnt_tick && (src_sel == CCA_SRC_DIV6)) [*5];
    endsequence

    sequence s_wrap;
        cf_q && (cnt_q == '0);
    endsequence

    counter_step_a: assert property (
        cnt_tick |=> (cnt_q == $past(cnt_q) + 1'b1))
        else $error("counter did not advance by one");

    div6_spacing_a: assert property (
        (s_div6_tick ##1 ((src_sel == CCA_SRC_DIV6) && run_en && !cnt_wr) [*5])
        |-> !$past(cnt_tick))
        else $error("divide by six tick too early");

    div6_phase_a: assert property (
        s_div6_tick |-> (presc_q == CCA_DIV6_LAST) ##1 s_quiet5)
        else $error("divide by six phase wrong");

    run_stop_a: assert property (
        (!cr_q && !cnt_wr) |=> (cnt_q == $past(cnt_q)))
        else $error("counter moved while stopped");

    overflow_wrap_a: assert property (
        ovf |=> s_wrap)
        else $error("overflow did not wrap and flag");

    overflow_hold_a: assert property (
        (cf_q && !wr_counter_run_and_flags) |=> cf_q)
        else $error("overflow flag lost without write");

    overflow_irq_a: assert property (
        (cf_q && counter_mode_control_q[CCA_CM_OVIE]) |-> irq)
        else $error("overflow interrupt missing");

    irq_quiet_a: assert property (
        (!(cf_q && counter_mode_control_q[CCA_CM_OVIE]) && ((ccf_q & irq_en) == '0)) |-> !irq)
        else $error("interrupt without cause");

    idle_gate_a: assert property (
        (idle_mode && counter_mode_control_q[CCA_CM_IDLE] && !cnt_wr) |=> (cnt_q == $past(cnt_q)))
        else $error("counter ran in gated idle");

    reserved_zero_a: assert property (
        (counter_mode_control_q & ~CCA_COUNTER_MODE_CONTROL_MASK) == CCA_BYTE_ZERO)
        else $error("reserved mode bits stored");

    watchdog_gate_a: assert property (
        wdt_reset |-> $past(counter_mode_control_q[CCA_CM_MODULE4_WATCHDOG_ENABLE]))
        else $error("watchdog fired while disabled");

endmodule
`default_nettype wire

// ===== tb/cca_pin_model.sv
// Port 1 pin model: external drivers, pull-ups and the device's own drive
`timescale 1ns/10ps
`default_nettype none
module cca_pin_model (
    // Device side
    input  wire logic [7:0] p1_out,
    input  wire logic [7:0] p1_oe_n,
    // Bench side
    input  wire logic [7:0] ext_drv,
    input  wire logic [7:0] ext_lvl,
    // Resolved pin levels
    output logic [7:0]      p1_in
);
    // A driven module pin shows the device's value, a released one the bench level when ext_drv is set, else the pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (p1_oe_n[i] == 1'b0) begin
                p1_in[i] = p1_out[i];
            end else if (ext_drv[i] == 1'b1) begin
                p1_in[i] = ext_lvl[i];
            end else begin
                p1_in[i] = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/test_cca_top.sv
// Self-checking bench for the counter array
`timescale 1ns/10ps
`default_nettype none
module test_cca_top;
    import cca_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} cca_reg_row_t;
    typedef struct packed {
        logic [7:0] counter_mode_control;
        logic       idle;
        logic [7:0] run;
        int         n;
        logic [7:0] e;
    } cca_cnt_row_t;
    logic       ref_clk;
    logic       rst;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_rdata;
    logic       idle_mode;
    logic       timer0_ovf;
    logic [7:0] p1_in;
    logic [7:0] p1_out;
    logic [7:0] p1_oe_n;
    logic       irq;
    logic       wdt_reset;
    logic [7:0] ext_lvl;
    logic [7:0] rd_v;
    int         failures;
    int         cmp_count;
    cca_reg_row_t reg_rows[10] = '{'{8'hD9, 8'hFF, 8'hC7}, '{8'hD9, 8'h00, 8'h00},
        '{8'hD8, 8'h80, 8'h80}, '{8'hD8, 8'h00, 8'h00}, '{8'hD8, 8'h20, 8'h00},
        '{8'hDA, 8'hFF, 8'h7F}, '{8'hDA, 8'h00, 8'h00}, '{8'hE2, 8'hA5, 8'hA5},
        '{8'hEC, 8'h5A, 8'h5A}, '{8'hF0, 8'hFF, 8'h00}};
    // Run windows span 4n+2 edges: divide by six gives n=4 -> 3, divide by two 2n+1
    cca_cnt_row_t cnt_rows[9] = '{'{8'h04, 1'b0, 8'h40, 7, 8'h07},
        '{8'h00, 1'b0, 8'h40, 4, 8'h03}, '{8'h02, 1'b0, 8'h40, 3, 8'h07},
        '{8'h84, 1'b1, 8'h40, 5, 8'h00}, '{8'h84, 1'b0, 8'h40, 5, 8'h05},
        '{8'h04, 1'b1, 8'h40, 3, 8'h03}, '{8'h04, 1'b0, 8'h00, 4, 8'h00},
        '{8'h06, 1'b0, 8'h40, 5, 8'h05}, '{8'h86, 1'b1, 8'h40, 4, 8'h00}};

    cca_top i_cca_top (.ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .idle_mode(idle_mode), .timer0_ovf(timer0_ovf), .p1_in(p1_in), .p1_out(p1_out),
        .p1_oe_n(p1_oe_n), .irq(irq), .wdt_reset(wdt_reset));
    cca_pin_model i_cca_pin_model (.p1_out(p1_out), .p1_oe_n(p1_oe_n),
        .ext_drv(8'hFF), .ext_lvl(ext_lvl), .p1_in(p1_in));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        chk8(nm, {7'h00, e}, {7'h00, g});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge ref_clk);
        sfr_rd = 1'b0;
        rd_v = sfr_rdata;
    endtask

    task automatic clr_cnt;
        wr(8'hE0, 8'h00);
        wr(8'hE1, 8'h00);
    endtask

    // One count pulse from timer 0 or the count pin, pin kept at clk/4
    task automatic pulse(input logic ext);
        if (ext) begin
            ext_lvl[CCA_PIN_ECI] = 1'b0;
            repeat (2) @(negedge ref_clk);
            ext_lvl[CCA_PIN_ECI] = 1'b1;
            repeat (2) @(negedge ref_clk);
        end else begin
            timer0_ovf = 1'b1;
            @(negedge ref_clk);
            timer0_ovf = 1'b0;
            repeat (3) @(negedge ref_clk);
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        $display("watchdog expired");
        summarize();
    end

    initial begin
        failures = 0;
        cmp_count = 0;
        rst = 1'b1;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        idle_mode = 1'b0;
        timer0_ovf = 1'b0;
        ext_lvl = 8'hFF;
        repeat (2) @(negedge ref_clk);
        chk8("p1_out", 8'hFF, p1_out);
        chk8("p1_oe_n", 8'hFF, p1_oe_n);
        chk1("irq", 1'b0, irq);
        rst = 1'b0;
        rd(8'hD9);
        chk8("mode ctl", 8'h00, rd_v);
        rd(8'hDE);
        chk8("module mode", 8'h00, rd_v);
        $display("test reset done");
        foreach (reg_rows[i]) begin
            wr(reg_rows[i].a, reg_rows[i].d);
            rd(reg_rows[i].a);
            chk8("register", reg_rows[i].e, rd_v);
        end
        $display("test registers done");
        foreach (cnt_rows[i]) begin
            wr(8'hD8, 8'h00);
            clr_cnt();
            wr(8'hD9, cnt_rows[i].counter_mode_control);
            idle_mode = cnt_rows[i].idle;
            wr(8'hD8, cnt_rows[i].run);
            for (int k = 0; k < cnt_rows[i].n; k++) pulse(cnt_rows[i].counter_mode_control[2:1] == 2'b11);
            wr(8'hD8, 8'h00);
            rd(8'hE0);
            chk8("counter", cnt_rows[i].e, rd_v);
        end
        idle_mode = 1'b0;
        $display("test count sources done");
        wr(8'hE0, 8'hFE);
        wr(8'hE1, 8'hFF);
        wr(8'hD9, 8'h03);
        wr(8'hD8, 8'h40);
        for (int k = 0; k < 40 && irq !== 1'b1; k++) @(negedge ref_clk);
        chk1("irq", 1'b1, irq);
        rd(8'hD8);
        chk8("run flags", 8'hC0, rd_v);
        rd(8'hE1);
        chk8("counter high", 8'h00, rd_v);
        wr(8'hD9, 8'h02);
        chk1("irq", 1'b0, irq);
        wr(8'hD8, 8'h00);
        $display("test overflow done");
        clr_cnt();
        wr(8'hE2, 8'h10);
        wr(8'hE8, 8'h00);
        wr(8'hDA, 8'h4D);
        chk1("pin drive", 1'b0, p1_oe_n[CCA_PIN_MOD0]);
        chk1("pin", 1'b1, p1_out[CCA_PIN_MOD0]);
        wr(8'hD8, 8'h40);
        for (int k = 0; k < 80 && irq !== 1'b1; k++) @(negedge ref_clk);
        chk1("irq", 1'b1, irq);
        chk1("pin", 1'b0, p1_out[CCA_PIN_MOD0]);
        rd(8'hD8);
        chk8("run flags", 8'h41, rd_v);
        wr(8'hDA, 8'h4C);
        chk1("irq", 1'b0, irq);
        wr(8'hD8, 8'h00);
        wr(8'hDA, 8'h00);
        $display("test match done");
        clr_cnt();
        wr(8'hE6, 8'h08);
        wr(8'hEC, 8'h00);
        wr(8'hDE, 8'h48);
        wr(8'hD9, 8'h42);
        wr(8'hD8, 8'h40);
        for (int k = 0; k < 80 && wdt_reset !== 1'b1; k++) @(negedge ref_clk);
        chk1("wdt_reset", 1'b1, wdt_reset);
        rd(8'hD8);
        chk8("run flags", 8'h50, rd_v);
        chk1("irq", 1'b0, irq);
        wr(8'hD8, 8'h00);
        wr(8'hDE, 8'h00);
        $display("test watchdog done");
        wr(8'hE0, 8'h34);
        wr(8'hE1, 8'h12);
        wr(8'hDB, 8'h20);
        ext_lvl[4] = 1'b0;
        repeat (3) @(negedge ref_clk);
        rd(8'hD8);
        chk8("run flags", 8'h00, rd_v);
        ext_lvl[4] = 1'b1;
        repeat (3) @(negedge ref_clk);
        rd(8'hD8);
        chk8("run flags", 8'h02, rd_v);
        rd(8'hE3);
        chk8("value low", 8'h34, rd_v);
        rd(8'hE9);
        chk8("value high", 8'h12, rd_v);
        wr(8'hE0, 8'h56);
        wr(8'hDB, 8'h10);
        ext_lvl[4] = 1'b0;
        repeat (3) @(negedge ref_clk);
        rd(8'hE3);
        chk8("value low", 8'h56, rd_v);
        wr(8'hDB, 8'h00);
        $display("test capture done");
        clr_cnt();
        wr(8'hE4, 8'h80);
        wr(8'hEA, 8'h80);
        wr(8'hDC, 8'h42);
        repeat (2) @(negedge ref_clk);
        chk1("pin drive", 1'b0, p1_oe_n[5]);
        chk1("pwm pin", 1'b0, p1_out[5]);
        wr(8'hE0, 8'hC0);
        repeat (2) @(negedge ref_clk);
        chk1("pwm pin", 1'b1, p1_out[5]);
        $display("test pwm done");
        summarize();
    end
endmodule
`default_nettype wire
